// ### verilog/trf_top.sv
// rate select and external front-end control block with APB registers
// Function
// - high-rate enable selects 625 kbps bit timing instead of 250 kbps
// - high-rate enable is bit 0 of baseband rate register 0x38
// - writing 1 to 0x2A bit 1 resets baseband so settings apply
// - test mode 111 at 0x22F hands pins 0..2 to front-end control
// - pins 0,1 high in transmit, low in receive; pin 2 opposite
module trf_top import trf_pkg::*; (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // general-purpose pins, normal function
    input wire logic [2:0] gp_out_sw,
    input wire logic [2:0] gp_oe_n_sw,
    // general-purpose pins
    output logic gp_pin_0_o,
    output logic gp_pin_0_oe_n,
    output logic gp_pin_1_o,
    output logic gp_pin_1_oe_n,
    output logic gp_pin_2_o,
    output logic gp_pin_2_oe_n,
    // baseband status
    output logic turbo_on,
    output logic bit_tick,
    output logic baseband_rst,
    output logic link_layer_rst,
    output logic power_rst
);
    logic [7:0] tickh_r, tickh_nxt;
    logic [7:0] amp_lo_r, amp_lo_nxt;
    logic [7:0] amp_hi_r, amp_hi_nxt;
    logic [7:0] txon_q_r, txon_q_nxt;
    logic [7:0] tx_stab_r, tx_stab_nxt;
    logic [7:0] bb0_r, bb0_nxt;
    logic [7:0] bb3_r, bb3_nxt;
    logic [7:0] bb4_r, bb4_nxt;
    logic [7:0] test_r, test_nxt;
    logic [TX_BITS_W-1:0] tx_bits_r, tx_bits_nxt;
    logic [2:0] srst_cnt_r, srst_cnt_nxt;
    logic [2:0] srst_kind_r, srst_kind_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic wr_en;
    logic rd_en;
    logic hit;
    logic tx_start;
    logic tx_busy;
    logic fe_tx;
    logic fe_mode;
    logic [7:0] rd_byte;
    logic [7:0] wb;

    // single-cycle access phase; every register answers at once
    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite && pstrb[0];
    // read byte is captured in setup so the access cycle shows it from a flop
    assign rd_en = psel && !penable && !pwrite;
    assign wb = pwdata[7:0];

    function automatic logic is_addr(input logic [ADDR_W-1:0] a, input logic [11:0] idx);
        is_addr = (a == reg_addr(idx));
    endfunction

    function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] mask,
                                         input logic [7:0] d, input logic we);
        merge = we ? (d & mask) : old;
    endfunction

    always_comb begin
        hit = 1'b1;
        rd_byte = 8'h00;
        if (is_addr(paddr, IDX_TICKH)) begin
            rd_byte = tickh_r;
        end else if (is_addr(paddr, IDX_AMP_LO)) begin
            rd_byte = amp_lo_r;
        end else if (is_addr(paddr, IDX_AMP_HI)) begin
            rd_byte = amp_hi_r;
        end else if (is_addr(paddr, IDX_TXON_Q)) begin
            rd_byte = txon_q_r;
        end else if (is_addr(paddr, IDX_SOFT_RESET)) begin
            rd_byte = {5'b00000, srst_kind_r};
        end else if (is_addr(paddr, IDX_TX_STABLE)) begin
            rd_byte = tx_stab_r;
        end else if (is_addr(paddr, IDX_BB0)) begin
            rd_byte = bb0_r;
        end else if (is_addr(paddr, IDX_BB3)) begin
            rd_byte = bb3_r;
        end else if (is_addr(paddr, IDX_BB4)) begin
            rd_byte = bb4_r;
        end else if (is_addr(paddr, IDX_TEST)) begin
            rd_byte = test_r;
        end else if (is_addr(paddr, IDX_RADIO_CTRL)) begin
            rd_byte = tx_bits_r[7:0];
        end else if (is_addr(paddr, IDX_RADIO_STAT)) begin
            rd_byte = {5'b00000, fe_mode, fe_tx, tx_busy};
        end else begin
            hit = 1'b0;
        end
    end
    // unmapped addresses answer with an error and write nothing
    assign pslverr = psel && penable && !hit;

    always_comb begin
        tickh_nxt = merge(tickh_r, 8'hFF, wb, wr_en && is_addr(paddr, IDX_TICKH));
        amp_lo_nxt = merge(amp_lo_r, 8'hFF, wb, wr_en && is_addr(paddr, IDX_AMP_LO));
        amp_hi_nxt = merge(amp_hi_r, MASK_AMP_HI, wb, wr_en && is_addr(paddr, IDX_AMP_HI));
        txon_q_nxt = merge(txon_q_r, MASK_TXON_Q, wb, wr_en && is_addr(paddr, IDX_TXON_Q));
        tx_stab_nxt = merge(tx_stab_r, 8'hFF, wb, wr_en && is_addr(paddr, IDX_TX_STABLE));
        bb0_nxt = merge(bb0_r, MASK_BB0, wb, wr_en && is_addr(paddr, IDX_BB0));
        bb3_nxt = merge(bb3_r, MASK_BB3, wb, wr_en && is_addr(paddr, IDX_BB3));
        bb4_nxt = merge(bb4_r, MASK_BB4, wb, wr_en && is_addr(paddr, IDX_BB4));
        test_nxt = merge(test_r, MASK_TEST, wb, wr_en && is_addr(paddr, IDX_TEST));
        tx_bits_nxt = tx_bits_r;
        tx_start = 1'b0;
        if (wr_en && is_addr(paddr, IDX_RADIO_CTRL)) begin
            // bits 12:1 set the length; a write with bit 0 set starts a transmission of that many bits when idle
            tx_bits_nxt = TX_BITS_W'(pwdata[TX_BITS_W:1]);
            tx_start = pwdata[F_TX_REQ] && !tx_busy;
        end
    end

    // soft reset: a write of 1 pulses the matching reset for a few cycles
    always_comb begin
        srst_cnt_nxt = (srst_cnt_r != 3'h0) ? srst_cnt_r - 3'h1 : 3'h0;
        srst_kind_nxt = (srst_cnt_r > 3'h1) ? srst_kind_r : 3'h0;
        if (wr_en && is_addr(paddr, IDX_SOFT_RESET) && (wb[2:0] != 3'h0)) begin
            srst_cnt_nxt = 3'(BB_RST_CYC);
            srst_kind_nxt = wb[2:0] | srst_kind_r;
        end
    end
    assign baseband_rst = srst_kind_r[F_RST_BB];
    assign link_layer_rst = srst_kind_r[F_RST_LINK];
    assign power_rst = srst_kind_r[F_RST_PWR];

    always_comb begin
        prdata_nxt = prdata_r;
        if (rd_en) begin
            prdata_nxt = {24'h00_0000, rd_byte};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tickh_r <= RST_ZERO;
            amp_lo_r <= RST_ZERO;
            amp_hi_r <= RST_ZERO;
            txon_q_r <= RST_ZERO;
            tx_stab_r <= RST_ZERO;
            bb0_r <= RST_ZERO;
            bb3_r <= RST_ZERO;
            bb4_r <= RST_ZERO;
            test_r <= RST_ZERO;
            tx_bits_r <= '0;
            srst_cnt_r <= 3'h0;
            srst_kind_r <= 3'h0;
            prdata_r <= 32'h0000_0000;
        end else begin
            tickh_r <= tickh_nxt;
            amp_lo_r <= amp_lo_nxt;
            amp_hi_r <= amp_hi_nxt;
            txon_q_r <= txon_q_nxt;
            tx_stab_r <= tx_stab_nxt;
            bb0_r <= bb0_nxt;
            bb3_r <= bb3_nxt;
            bb4_r <= bb4_nxt;
            test_r <= test_nxt;
            tx_bits_r <= tx_bits_nxt;
            srst_cnt_r <= srst_cnt_nxt;
            srst_kind_r <= srst_kind_nxt;
            prdata_r <= prdata_nxt;
        end
    end
    // loaded at the setup edge, so it stands through the whole access cycle
    assign prdata = prdata_r;

    // rate only changes after the baseband soft reset, so a half-written setup never runs
    logic turbo_live_r, turbo_live_nxt;
    always_comb begin
        turbo_live_nxt = baseband_rst ? bb0_r[F_TURBO] : turbo_live_r;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            turbo_live_r <= 1'b0;
        end else begin
            turbo_live_r <= turbo_live_nxt;
        end
    end
    assign turbo_on = turbo_live_r;

    trf_bit_tick u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .bb_rst(baseband_rst),
        .turbo(turbo_live_r),
        .bit_tick(bit_tick)
    );

    trf_fe_ctrl u_fe (
        .pclk(pclk),
        .presetn(presetn),
        .bb_rst(baseband_rst),
        .amp_on_delay({amp_hi_r[0], amp_lo_r}),
        .tx_on_delay({txon_q_r[1:0], tickh_r[7:1]}),
        .bit_tick(bit_tick),
        .tx_bits(tx_bits_r),
        .tx_start(tx_start),
        .tx_busy(tx_busy),
        .fe_tx(fe_tx)
    );

    assign fe_mode = (test_r[2:0] == TEST_MODE_FE);
    always_comb begin
        if (fe_mode) begin
            gp_pin_0_o = fe_tx;
            gp_pin_1_o = fe_tx;
            gp_pin_2_o = !fe_tx;
            gp_pin_0_oe_n = 1'b0;
            gp_pin_1_oe_n = 1'b0;
            gp_pin_2_oe_n = 1'b0;
        end else begin
            gp_pin_0_o = gp_out_sw[0];
            gp_pin_1_o = gp_out_sw[1];
            gp_pin_2_o = gp_out_sw[2];
            gp_pin_0_oe_n = gp_oe_n_sw[0];
            gp_pin_1_oe_n = gp_oe_n_sw[1];
            gp_pin_2_oe_n = gp_oe_n_sw[2];
        end
    end
endmodule

// ### verilog/trf_pkg.sv
// package: register map, field layout, reset values and timing for the rate/front-end block
package trf_pkg;
    // register indices; the byte address is index * 4
    localparam logic [11:0] IDX_TICKH = 12'h015;
    localparam logic [11:0] IDX_AMP_LO = 12'h016;
    localparam logic [11:0] IDX_AMP_HI = 12'h017;
    localparam logic [11:0] IDX_TXON_Q = 12'h018;
    localparam logic [11:0] IDX_SOFT_RESET = 12'h02A;
    localparam logic [11:0] IDX_TX_STABLE = 12'h02E;
    localparam logic [11:0] IDX_BB0 = 12'h038;
    localparam logic [11:0] IDX_BB3 = 12'h03B;
    localparam logic [11:0] IDX_BB4 = 12'h03C;
    localparam logic [11:0] IDX_TEST = 12'h22F;
    // own registers: radio state control and status
    localparam logic [11:0] IDX_RADIO_CTRL = 12'h300;
    localparam logic [11:0] IDX_RADIO_STAT = 12'h301;
    localparam int ADDR_W = 14;
    // field positions
    localparam int F_TURBO = 0;
    localparam int F_RST_LINK = 0;
    localparam int F_RST_BB = 1;
    localparam int F_RST_PWR = 2;
    localparam int F_TX_REQ = 0;
    localparam logic [2:0] TEST_MODE_FE = 3'h7;
    localparam logic [3:0] PREVALID_TURBO = 4'h3;
    localparam logic [2:0] CS_THRESH_TURBO = 3'h2;
    // writable bit masks (reserved bits read zero)
    localparam logic [7:0] MASK_AMP_HI = 8'h1F;
    localparam logic [7:0] MASK_TXON_Q = 8'hBF;
    localparam logic [7:0] MASK_BB0 = 8'h01;
    localparam logic [7:0] MASK_BB3 = 8'hFE;
    localparam logic [7:0] MASK_BB4 = 8'hFC;
    localparam logic [7:0] MASK_TEST = 8'h1F;
    // reset values
    localparam logic [7:0] RST_ZERO = 8'h00;
    // rates and timing
    localparam int CLK_HZ = 10_000_000;
    localparam int RATE_STD_BPS = 250_000;
    localparam int RATE_TURBO_BPS = 625_000;
    localparam int BIT_CYC_STD = CLK_HZ / RATE_STD_BPS;
    localparam int BIT_CYC_TURBO = CLK_HZ / RATE_TURBO_BPS;
    localparam int BB_RST_CYC = 4;
    localparam int TX_BITS_W = 12;
    typedef enum logic [3:0] {
        FE_RX = 4'b0001,
        FE_PA_WAIT = 4'b0010,
        FE_TX = 4'b0100,
        FE_TX_END = 4'b1000
    } trf_fe_t;
    function automatic logic [ADDR_W-1:0] reg_addr(input logic [11:0] idx);
        reg_addr = {idx, 2'b00};
    endfunction
endpackage

// ### verilog/trf_bit_tick.sv
// bit-rate tick generator for the baseband, standard or high rate
module trf_bit_tick import trf_pkg::*; (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic bb_rst,
    input wire logic turbo,
    // tick out
    output logic bit_tick
);
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic [7:0] limit;
    always_comb begin
        limit = turbo ? 8'(BIT_CYC_TURBO - 1) : 8'(BIT_CYC_STD - 1);
        cnt_nxt = (bb_rst || cnt_r >= limit) ? 8'h00 : cnt_r + 8'h01;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 8'h00;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
    assign bit_tick = !bb_rst && (cnt_r == limit);
endmodule

// ### verilog/trf_fe_ctrl.sv
// front-end sequencer: amplifier turn-on delay before and transmit turn-off delay after each transmission
module trf_fe_ctrl import trf_pkg::*; (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic bb_rst,
    // timing
    input wire logic [8:0] amp_on_delay,
    input wire logic [8:0] tx_on_delay,
    input wire logic bit_tick,
    input wire logic [TX_BITS_W-1:0] tx_bits,
    // request and state
    input wire logic tx_start,
    output logic tx_busy,
    output logic fe_tx
);
    trf_fe_t st_r, st_nxt;
    logic [TX_BITS_W-1:0] cnt_r, cnt_nxt;
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        unique case (st_r)
            FE_RX: begin
                if (tx_start) begin
                    st_nxt = FE_PA_WAIT;
                    cnt_nxt = TX_BITS_W'(amp_on_delay);
                end
            end
            FE_PA_WAIT: begin
                if (cnt_r == '0) begin
                    st_nxt = FE_TX;
                    cnt_nxt = tx_bits;
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            FE_TX: begin
                if (cnt_r == '0) begin
                    st_nxt = FE_TX_END;
                    cnt_nxt = TX_BITS_W'(tx_on_delay);
                end else if (bit_tick) begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            FE_TX_END: begin
                if (cnt_r == '0) begin
                    st_nxt = FE_RX;
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            default: begin
                st_nxt = FE_RX;
                cnt_nxt = '0;
            end
        endcase
        if (bb_rst) begin
            st_nxt = FE_RX;
            cnt_nxt = '0;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= FE_RX;
            cnt_r <= '0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
        end
    end
    assign tx_busy = (st_r != FE_RX);
    // outputs stay in transmit polarity until the turn-off delay ends
    assign fe_tx = (st_r == FE_TX) || (st_r == FE_TX_END);
endmodule

// ### dv/trf_top_monitor.sv
// checker: apb, rate and front-end pin relations of the rate/front-end block
module trf_top_monitor import trf_pkg::*; (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pready,
    input wire logic pslverr,
    // pins
    input wire logic [2:0] gp_out_sw,
    input wire logic [2:0] gp_oe_n_sw,
    input wire logic gp_pin_0_o,
    input wire logic gp_pin_0_oe_n,
    input wire logic gp_pin_1_o,
    input wire logic gp_pin_1_oe_n,
    input wire logic gp_pin_2_o,
    input wire logic gp_pin_2_oe_n,
    // baseband
    input wire logic turbo_on,
    input wire logic bit_tick,
    input wire logic baseband_rst,
    input wire logic link_layer_rst,
    input wire logic power_rst
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr, srst;
    logic fe_r, fe_nxt, ok_r, ok_nxt;
    logic [5:0] gap_r, gap_nxt;
    assign wr = psel && penable && pready && pwrite && pstrb[0];
    assign srst = wr && paddr == {IDX_SOFT_RESET, 2'b00};
    always_comb begin
        fe_nxt = fe_r;
        if (wr && paddr == {IDX_TEST, 2'b00}) begin
            fe_nxt = pwdata[2:0] == TEST_MODE_FE;
        end
        gap_nxt = bit_tick ? 6'h01 : gap_r + 6'h01;
        // spacing is only known once a tick has passed since the last baseband reset
        ok_nxt = baseband_rst ? 1'b0 : (bit_tick ? 1'b1 : ok_r);
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fe_r <= 1'b0;
            ok_r <= 1'b0;
            gap_r <= 6'h00;
        end else begin
            fe_r <= fe_nxt;
            ok_r <= ok_nxt;
            gap_r <= gap_nxt;
        end
    end
    AST_PREADY: assert property (psel && penable |-> pready)
        else $error("pready low in access phase");
    AST_ERR_PHASE: assert property (pslverr |-> psel && penable)
        else $error("pslverr outside access phase");
    AST_RATE: assert property (bit_tick && ok_r |-> gap_r == (turbo_on ? 6'h10 : 6'h28))
        else $error("bit tick spacing wrong");
    AST_TURBO_APPLY: assert property ($changed(turbo_on) |-> $past(baseband_rst))
        else $error("rate changed without baseband reset");
    AST_BB_RST: assert property (srst && pwdata[F_RST_BB] |-> ##[1:5] baseband_rst)
        else $error("baseband reset missing");
    AST_LINK_RST: assert property (srst && pwdata[F_RST_LINK] |-> ##[1:5] link_layer_rst)
        else $error("link reset missing");
    AST_PWR_RST: assert property (srst && pwdata[F_RST_PWR] |-> ##[1:5] power_rst)
        else $error("power reset missing");
    AST_FE_PINS: assert property (fe_r |-> !gp_pin_0_oe_n && !gp_pin_1_oe_n && !gp_pin_2_oe_n
        && gp_pin_1_o == gp_pin_0_o && gp_pin_2_o != gp_pin_0_o)
        else $error("front-end pin levels wrong");
    AST_SW_PINS: assert property (!fe_r |-> {gp_pin_2_o, gp_pin_1_o, gp_pin_0_o} == gp_out_sw
        && {gp_pin_2_oe_n, gp_pin_1_oe_n, gp_pin_0_oe_n} == gp_oe_n_sw)
        else $error("pins not following software");
endmodule
bind trf_top trf_top_monitor trf_top_monitor_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .pslverr(pslverr), .gp_out_sw(gp_out_sw), .gp_oe_n_sw(gp_oe_n_sw),
    .gp_pin_0_o(gp_pin_0_o), .gp_pin_0_oe_n(gp_pin_0_oe_n), .gp_pin_1_o(gp_pin_1_o),
    .gp_pin_1_oe_n(gp_pin_1_oe_n), .gp_pin_2_o(gp_pin_2_o), .gp_pin_2_oe_n(gp_pin_2_oe_n),
    .turbo_on(turbo_on), .bit_tick(bit_tick), .baseband_rst(baseband_rst),
    .link_layer_rst(link_layer_rst), .power_rst(power_rst));

// ### dv/trf_fe_model.sv
// front-end model: external amplifier, low-noise amplifier and switches on three pins
module trf_fe_model (
    // pins from the block
    input wire logic [2:0] pin_o,
    input wire logic [2:0] pin_oe_n,
    // front-end state
    output logic pa_on,
    output logic lna_on
);
    // an undriven pin counts as off: enables are pulled down on the board
    assign pa_on = !pin_oe_n[0] && pin_o[0] && !pin_oe_n[1] && pin_o[1];
    assign lna_on = !pin_oe_n[2] && pin_o[2];
endmodule

// ### dv/trf_top_tb_top.sv
// testbench: register, rate and front-end pin tests for the rate/front-end block
module trf_top_tb_top import trf_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic [3:0] pstrb = 4'hF;
    logic [2:0] gp_out_sw = 3'h5, gp_oe_n_sw = 3'h2;
    logic pready, pslverr, p0, e0, p1, e1, p2, e2, turbo_on, bit_tick, pa_on, lna_on;
    logic [7:0] q;
    int n_fail = 0, tests_run = 0, cyc = 0, k;
    localparam logic [11:0] RIDX [9] = '{IDX_TICKH, IDX_AMP_LO, IDX_AMP_HI, IDX_TXON_Q,
        IDX_TX_STABLE, IDX_BB0, IDX_BB3, IDX_BB4, IDX_TEST};
    localparam logic [7:0] RMSK [9] = '{8'hFF, 8'hFF, MASK_AMP_HI, MASK_TXON_Q, 8'hFF,
        MASK_BB0, MASK_BB3, MASK_BB4, MASK_TEST};
    always #50 pclk = ~pclk;
    trf_top trf_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .gp_out_sw(gp_out_sw), .gp_oe_n_sw(gp_oe_n_sw),
        .gp_pin_0_o(p0), .gp_pin_0_oe_n(e0), .gp_pin_1_o(p1), .gp_pin_1_oe_n(e1),
        .gp_pin_2_o(p2), .gp_pin_2_oe_n(e2), .turbo_on(turbo_on), .bit_tick(bit_tick),
        .baseband_rst(), .link_layer_rst(), .power_rst());
    trf_fe_model trf_fe_model_i (.pin_o({p2, p1, p0}), .pin_oe_n({e2, e1, e0}),
        .pa_on(pa_on), .lna_on(lna_on));
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {a, 2'b00};
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (!pready && cyc < 20000);
        q = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 8'h00);
    endtask
    // period between two ticks, in clock cycles
    task automatic gap(output int c);
        repeat (100) begin @(negedge pclk); if (bit_tick) break; end
        c = 0;
        repeat (100) begin @(negedge pclk); c++; if (bit_tick) break; end
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            finish_test();
        end
    end
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk({e2, e1, e0, p2, p1, p0}, {gp_oe_n_sw, gp_out_sw});
        for (int i = 0; i < 9; i++) begin
            rd(RIDX[i]);
            chk(q, 0);
            wr(RIDX[i], 8'hFF);
            rd(RIDX[i]);
            chk(q, RMSK[i]);
            wr(RIDX[i], 8'h00);
        end
        rd(12'h0FF);
        chk({err, q}, 16'h0100);
        pstrb <= 4'hE;
        wr(IDX_BB0, 8'h01);
        pstrb <= 4'hF;
        rd(IDX_BB0);
        chk(q, 0);
        $display("test regs done");
        wr(IDX_BB3, {PREVALID_TURBO, 4'h0});
        wr(IDX_BB4, {CS_THRESH_TURBO, 5'h00});
        wr(IDX_SOFT_RESET, 8'h05);
        for (int m = 1; m >= 0; m--) begin
            wr(IDX_BB0, m[7:0]);
            chk(turbo_on, 1 - m);
            wr(IDX_SOFT_RESET, 8'h02);
            k = 0;
            while (turbo_on !== m[0] && k < 20) begin @(negedge pclk); k++; end
            chk(turbo_on, m);
            gap(k);
            chk(16'(k), 16'(m ? BIT_CYC_TURBO : BIT_CYC_STD));
        end
        $display("test rate done");
        wr(IDX_AMP_LO, 8'h03);
        wr(IDX_TICKH, 8'h04);
        wr(IDX_TEST, 8'h07);
        @(negedge pclk);
        chk({e2, e1, e0, p2, p1, p0, pa_on, lna_on}, 16'h0011);
        rd(IDX_RADIO_STAT);
        chk(q, 8'h04);
        // two bits, standard rate, amplifier delay 3, transmit delay 2
        wr(IDX_RADIO_CTRL, 8'h05);
        k = 0;
        while (k < 50) begin @(negedge pclk); if (p0) break; @(posedge pclk); k++; end
        chk(16'(k), 4);
        chk({e2, e1, e0, p2, p1, p0, pa_on, lna_on}, 16'h000E);
        k = 0;
        while (p0 && k < 200) begin @(negedge pclk); k++; end
        // one to two bit periods, one cycle to leave, then transmit delay 2 plus one
        chk(k >= 45 && k <= 84, 1);
        chk({p2, p1, p0, pa_on, lna_on}, 16'h0011);
        wr(IDX_TEST, 8'h00);
        @(negedge pclk);
        chk({e2, e1, e0, p2, p1, p0}, {gp_oe_n_sw, gp_out_sw});
        $display("test front-end done");
        @(posedge pclk);
        finish_test();
    end
endmodule
